/* verilog/cmpint_pkg.sv */
// constants and types for the comparator mode and change interrupt block
package cmpint_pkg;
	// register byte addresses (apb, one word each)
	localparam logic [11:0] CMPINT_CTRL_OFS    = 12'h000;
	localparam logic [11:0] CMPINT_FLAG_OFS    = 12'h004;
	localparam logic [11:0] CMPINT_EN_OFS      = 12'h008;
	localparam logic [11:0] CMPINT_INTERRUPT_CONTROL_REG_OFS  = 12'h00c;
	localparam logic [11:0] CMPINT_STAT_OFS    = 12'h010;
	localparam logic [11:0] CMPINT_SLEEP_OFS   = 12'h014;
	// field positions
	localparam int CMPINT_MODE_LSB   = 0;
	localparam int CMPINT_OUT1_BIT   = 6;
	localparam int CMPINT_OUT2_BIT   = 7;
	localparam int CMPINT_CHG_BIT    = 6;
	localparam int CMPINT_CHGEN_BIT  = 6;
	localparam int CMPINT_PERIPHERAL_INT_ENABLE_BIT   = 6;
	localparam int CMPINT_GIE_BIT    = 7;
	localparam int CMPINT_SETTLE_BIT = 0;
	localparam int CMPINT_WAKE_BIT   = 1;
	// mode values: after reset, and comparators off
	localparam logic [2:0] CMPINT_MODE_RST  = 3'h0;
	localparam logic [2:0] CMPINT_MODE_OFF  = 3'h7;
	// mode-change settling time and its cycle count at 20 mhz
	localparam int CMPINT_CLK_MHZ       = 20;
	localparam int CMPINT_SETTLE_NS     = 10000;
	localparam int CMPINT_SETTLE_CYC    = (CMPINT_SETTLE_NS * CMPINT_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] CMPINT_SETTLE_W = CMPINT_SETTLE_CYC[7:0];
	// quarter phases of one instruction cycle
	typedef enum logic [1:0] {
		CMPINT_Q1,
		CMPINT_Q2,
		CMPINT_Q3,
		CMPINT_Q4
	} cmpint_phase_e;
endpackage : cmpint_pkg

/* verilog/cmpint_sync.sv */
// two-flop synchroniser for the comparator outputs
`timescale 1ns/10ps
module cmpint_sync
	import cmpint_pkg::*;
#(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// async in, synced out
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] d_sync
);
	logic [W-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			d_sync <= '0;
		end else begin
			meta_r <= d_async;
			d_sync <= meta_r;
		end
	end
endmodule : cmpint_sync

/* verilog/cmpint_phase.sv */
// quarter-phase generator for the instruction cycle
`timescale 1ns/10ps
module cmpint_phase
	import cmpint_pkg::*;
(
	// clock and reset
	input  wire logic    pclk,
	input  wire logic    presetn,
	// current quarter phase
	output cmpint_phase_e phase
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= CMPINT_Q1;
		end else begin
			case (phase)
				CMPINT_Q1: phase <= CMPINT_Q2;
				CMPINT_Q2: phase <= CMPINT_Q3;
				CMPINT_Q3: phase <= CMPINT_Q4;
				CMPINT_Q4: phase <= CMPINT_Q1;
				default:   phase <= CMPINT_Q1;
			endcase
		end
	end
endmodule : cmpint_phase

/* verilog/cmpint_top.sv */
// comparator mode control, change flag and interrupt, apb slave
`timescale 1ns/10ps
//
// Overview of operation
// - eight comparator modes selected by a three-bit mode field.
// - output bits may be invalid during settling after a mode change.
// - change flag sets when either output differs from latched value.
// - both comparator outputs read in control register bits 7:6.
// - change flag at flag register bit 6, cleared by writing zero.
// - writing one to the change flag sets it like a real change.
// - interrupt only when change enable, peripheral and global enables set.
// - flag still sets when any enable is clear.
// - change coincident with a control read in phase two may be missed.
// - any control register read or write relatches the outputs.
// - persisting mismatch keeps setting the flag after clearing.
// - active comparator keeps running and flagging during sleep.
// - enabled change interrupt wakes the device from sleep.
// - mode 111 turns both comparators off.
// - waking from sleep leaves the control register unchanged.
// - reset returns control register to mode 000.
module cmpint_top
	import cmpint_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog comparator side
	input  wire logic        first_comparator_output,
	input  wire logic        second_comparator_output,
	output logic      [2:0]  comparator_mode_field,
	output logic             comparators_off,
	// core side
	input  wire logic        sleep_req,
	output logic             irq,
	output logic             wake
);
	logic [1:0]    cmp_sync;
	cmpint_phase_e phase;
	logic [1:0]    latched_r;
	logic          chg_flag_r;
	logic          chg_en_r;
	logic          peripheral_int_enable_r;
	logic          gie_r;
	logic          asleep_r;
	logic [7:0]    settle_r;
	logic          wr_acc;
	logic          rd_acc;
	logic          ctrl_hit;
	logic          mismatch;
	logic          req;
	logic [31:0]   rdata_nxt;

	// decode a register address to a one-word hit
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	cmpint_sync #(
		.W(2)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d_async ({second_comparator_output, first_comparator_output}),
		.d_sync  (cmp_sync)
	);

	cmpint_phase u_phase (
		.pclk    (pclk),
		.presetn (presetn),
		.phase   (phase)
	);

	// zero-wait apb: every access completes in its first access cycle
	assign wr_acc   = psel && penable && pwrite;
	assign rd_acc   = psel && penable && !pwrite;
	assign ctrl_hit = addr_hit(paddr, CMPINT_CTRL_OFS);
	assign mismatch = (cmp_sync != latched_r);
	assign req      = chg_flag_r && chg_en_r && peripheral_int_enable_r && gie_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_mode_field <= CMPINT_MODE_RST;
		end else if (wr_acc && ctrl_hit) begin
			comparator_mode_field <= pwdata[CMPINT_MODE_LSB +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparators_off <= 1'b0;
		end else if (wr_acc && ctrl_hit) begin
			comparators_off <= (pwdata[CMPINT_MODE_LSB +: 3] == CMPINT_MODE_OFF);
		end
	end

	// settling window after a write that changes the mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_r <= 8'h00;
		end else if (wr_acc && ctrl_hit
			&& pwdata[CMPINT_MODE_LSB +: 3] != comparator_mode_field) begin
			settle_r <= CMPINT_SETTLE_W;
		end else if (settle_r != 8'h00) begin
			settle_r <= settle_r - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_r <= 2'h0;
		end else if (psel && penable && ctrl_hit) begin
			latched_r <= cmp_sync;
		end
	end

	// change flag: hardware set beats software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_flag_r <= 1'b0;
		end else if (mismatch && !(rd_acc && ctrl_hit && phase == CMPINT_Q2)) begin
			// set while mismatch stands, enables ignored
			// a control register read landing in phase two may swallow the set
			chg_flag_r <= 1'b1;
		end else if (wr_acc && addr_hit(paddr, CMPINT_FLAG_OFS)) begin
			// write zero clears, write one sets
			chg_flag_r <= pwdata[CMPINT_CHG_BIT];
		end
	end

	// enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_en_r <= 1'b0;
			peripheral_int_enable_r   <= 1'b0;
			gie_r    <= 1'b0;
		end else if (wr_acc) begin
			if (addr_hit(paddr, CMPINT_EN_OFS)) begin
				chg_en_r <= pwdata[CMPINT_CHGEN_BIT];
			end
			if (addr_hit(paddr, CMPINT_INTERRUPT_CONTROL_REG_OFS)) begin
				peripheral_int_enable_r <= pwdata[CMPINT_PERIPHERAL_INT_ENABLE_BIT];
				gie_r  <= pwdata[CMPINT_GIE_BIT];
			end
		end
	end

	// sleep state; leaves it on an enabled change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asleep_r <= 1'b0;
			wake     <= 1'b0;
		end else begin
			// wake ignores the global enable, as on the core
			wake <= asleep_r && chg_flag_r && chg_en_r;
			if (asleep_r && chg_flag_r && chg_en_r) begin
				asleep_r <= 1'b0;
			end else if (sleep_req) begin
				asleep_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= req;
		end
	end

	// read mux
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			CMPINT_CTRL_OFS: begin
				// outputs in bits 7:6, zero while settling
				rdata_nxt[CMPINT_MODE_LSB +: 3] = comparator_mode_field;
				rdata_nxt[CMPINT_OUT1_BIT] = cmp_sync[0] && (settle_r == 8'h00);
				rdata_nxt[CMPINT_OUT2_BIT] = cmp_sync[1] && (settle_r == 8'h00);
			end
			CMPINT_FLAG_OFS:   rdata_nxt[CMPINT_CHG_BIT] = chg_flag_r;
			CMPINT_EN_OFS:     rdata_nxt[CMPINT_CHGEN_BIT] = chg_en_r;
			CMPINT_INTERRUPT_CONTROL_REG_OFS: begin
				rdata_nxt[CMPINT_PERIPHERAL_INT_ENABLE_BIT] = peripheral_int_enable_r;
				rdata_nxt[CMPINT_GIE_BIT]  = gie_r;
			end
			CMPINT_STAT_OFS: begin
				rdata_nxt[CMPINT_SETTLE_BIT] = (settle_r != 8'h00);
				rdata_nxt[CMPINT_WAKE_BIT]   = asleep_r;
			end
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// registered read data; pready registered high, one-cycle access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !(addr_hit(paddr, CMPINT_CTRL_OFS)
				|| addr_hit(paddr, CMPINT_FLAG_OFS) || addr_hit(paddr, CMPINT_EN_OFS)
				|| addr_hit(paddr, CMPINT_INTERRUPT_CONTROL_REG_OFS) || addr_hit(paddr, CMPINT_STAT_OFS));
			if (psel && !penable && !pwrite) begin
				prdata <= rdata_nxt;
			end
		end
	end
endmodule : cmpint_top

/* verif/cmpint_cmp_model.sv */
// behavioural pair of analog comparators
`timescale 1ns/10ps
module cmpint_cmp_model (
	// requested outcome and power
	input  wire logic [1:0] level,
	input  wire logic       off,
	// results, unrelated to the clock
	output logic            cmp1,
	output logic            cmp2
);
	// off reads low; sleep does not stop them
	assign #7 {cmp2, cmp1} = off ? 2'h0 : level;
endmodule : cmpint_cmp_model

/* verif/cmpint_props.sv */
// assertions on the comparator interrupt block ports
`timescale 1ns/10ps
module cmpint_props
	import cmpint_pkg::*;
(
	// clock, reset, apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// comparator and core side
	input wire logic        first_comparator_output,
	input wire logic        second_comparator_output,
	input wire logic [2:0]  comparator_mode_field,
	input wire logic        comparators_off,
	input wire logic        sleep_req,
	input wire logic        irq,
	input wire logic        wake
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       acc;
	logic       cw;
	logic [7:0] settle_r;
	assign acc = psel && penable;
	assign cw = acc && pwrite && paddr == CMPINT_CTRL_OFS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settle_r <= 8'h00;
		else if (cw && pwdata[2:0] != comparator_mode_field)
			settle_r <= CMPINT_SETTLE_W;
		else if (settle_r != 8'h00)
			settle_r <= settle_r - 8'h01;
	end
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("no zero-wait answer");
	// prdata is only reloaded for reads; a write leaves the last read word standing
	property p_unmap;
		acc && paddr == CMPINT_SLEEP_OFS |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not refused");
	property p_mode_wr; cw |=> comparator_mode_field == $past(pwdata[2:0]); endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode not written");
	property p_hold; $changed(comparator_mode_field) |-> $past(cw); endproperty
	a_hold: assert property (p_hold) else $error("mode changed unasked");
	property p_off; comparators_off == (comparator_mode_field == CMPINT_MODE_OFF); endproperty
	a_off: assert property (p_off) else $error("off state wrong");
	property p_rst; $rose(presetn) |-> comparator_mode_field == CMPINT_MODE_RST; endproperty
	a_rst: assert property (p_rst) else $error("mode not reset");
	property p_settle;
		acc && !pwrite && paddr == CMPINT_CTRL_OFS && settle_r > 8'h02 |-> prdata[7:6] == 2'h0;
	endproperty
	a_settle: assert property (p_settle) else $error("outputs shown while settling");
	property p_irq_fall; $fell(irq) |-> $past(acc && pwrite, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped unasked");
endmodule : cmpint_props

/* verif/tb.sv */
// self-checking bench for the comparator interrupt block
`timescale 1ns/10ps
module tb;
	import cmpint_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, sleep_req, pready, pslverr;
	logic        c1, c2, irq, wake, off, err_seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [1:0]  level;
	logic [2:0]  mode;
	int          errors, num_checks, i;
	cmpint_cmp_model cmp_u (.level(level), .off(off), .cmp1(c1), .cmp2(c2));
	cmpint_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .first_comparator_output(c1), .second_comparator_output(c2),
		.comparator_mode_field(mode), .comparators_off(off), .sleep_req(sleep_req),
		.irq(irq), .wake(wake));
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata;
		err_seen = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : xfer
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		xfer(a, 1'h0, 32'h0);
		chk(rdat, e);
	endtask : rd
	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#(3000 * 50);
		errors++;
		end_sim();
	end
	initial begin
		{presetn, psel, penable, pwrite, sleep_req} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		level = 2'h3;
		cyc(16);
		presetn <= 1'h1;
		rd(CMPINT_CTRL_OFS, 32'h0);
		xfer(CMPINT_CTRL_OFS, 1'h1, 32'h2);
		rd(CMPINT_CTRL_OFS, 32'h2);
		cyc(210);
		rd(CMPINT_CTRL_OFS, 32'hc2);
		xfer(CMPINT_FLAG_OFS, 1'h1, 32'h0);
		level <= 2'h1;
		cyc(6);
		rd(CMPINT_FLAG_OFS, 32'h40);
		// enables only after the mode change
		xfer(CMPINT_EN_OFS, 1'h1, 32'h40);
		xfer(CMPINT_INTERRUPT_CONTROL_REG_OFS, 1'h1, 32'h40);
		chk({31'h0, irq}, 32'h0);
		xfer(CMPINT_INTERRUPT_CONTROL_REG_OFS, 1'h1, 32'hc0);
		cyc(1);
		chk({31'h0, irq}, 32'h1);
		rd(CMPINT_EN_OFS, 32'h40);
		rd(CMPINT_INTERRUPT_CONTROL_REG_OFS, 32'hc0);
		xfer(CMPINT_FLAG_OFS, 1'h1, 32'h0);
		rd(CMPINT_FLAG_OFS, 32'h40);
		rd(CMPINT_CTRL_OFS, 32'h42);
		xfer(CMPINT_FLAG_OFS, 1'h1, 32'h0);
		rd(CMPINT_FLAG_OFS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		xfer(CMPINT_FLAG_OFS, 1'h1, 32'h40);
		// irq is registered one edge after the flag, so look one edge later
		cyc(1);
		chk({31'h0, irq}, 32'h1);
		xfer(CMPINT_FLAG_OFS, 1'h1, 32'h0);
		sleep_req <= 1'h1;
		cyc(1);
		sleep_req <= 1'h0;
		rd(CMPINT_STAT_OFS, 32'h2);
		level <= 2'h0;
		i = 0;
		while (wake !== 1'h1 && i < 20) begin
			cyc(1);
			i++;
		end
		chk({31'h0, wake}, 32'h1);
		rd(CMPINT_CTRL_OFS, 32'h2);
		xfer(CMPINT_SLEEP_OFS, 1'h1, 32'hffffffff);
		chk({31'h0, err_seen}, 32'h1);
		rd(CMPINT_SLEEP_OFS, 32'h0);
		chk({31'h0, err_seen}, 32'h1);
		xfer(CMPINT_CTRL_OFS, 1'h1, 32'h7);
		chk({31'h0, off}, 32'h1);
		presetn <= 1'h0;
		cyc(2);
		presetn <= 1'h1;
		cyc(1);
		rd(CMPINT_CTRL_OFS, 32'h0);
		end_sim();
	end
endmodule : tb
bind cmpint_top cmpint_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .first_comparator_output(first_comparator_output),
	.second_comparator_output(second_comparator_output), .sleep_req(sleep_req),
	.comparator_mode_field(comparator_mode_field), .comparators_off(comparators_off),
	.irq(irq), .wake(wake));
